/* File: include/rpms_cfg.svh */
// Timing and encoding constants for the radio power mode sequencer.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef RPMS_CFG_SVH
`define RPMS_CFG_SVH

`define RPMS_CLK_PERIOD_NS      10
`define RPMS_XO_START_US        5000
`define RPMS_PLL_LOCK_US        500
`define RPMS_SHUTDOWN_US        1000
`define RPMS_MODE_SLEEP         3'h0
`define RPMS_MODE_STANDBY       3'h1
`define RPMS_MODE_SYNTH         3'h2
`define RPMS_MODE_RX            3'h3
`define RPMS_MODE_TX            3'h4
`define RPMS_CNT_W              20

`endif

/* File: include/rpms_pkg.sv */
// Types for the radio power mode sequencer.
// Assumes nothing of its surroundings.
package rpms_pkg;
    typedef enum logic [2:0] {
        RPMS_ST_SLEEP,
        RPMS_ST_XO_START,
        RPMS_ST_STANDBY,
        RPMS_ST_PLL_START,
        RPMS_ST_SYNTH,
        RPMS_ST_RX,
        RPMS_ST_TX,
        RPMS_ST_SHUTDOWN
    } rpms_state_t;
endpackage

/* File: design/rpms_timer.sv */
// Down-counting delay timer used for start-up and shutdown waits.
// Assumes load and count values from the sequencer, one clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "rpms_cfg.svh"
module rpms_timer (
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic                   load,
    input  wire logic [`RPMS_CNT_W-1:0] load_val,
    output logic                        done
);
    logic [`RPMS_CNT_W-1:0] cnt_r;
    logic [`RPMS_CNT_W-1:0] cnt_nxt;

    always_comb
    begin
        cnt_nxt = cnt_r;
        if (load)
            cnt_nxt = load_val;
        else if (cnt_r != '0)
            cnt_nxt = cnt_r - 1'b1;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

    assign done = (cnt_r == '0) && !load;
endmodule
`default_nettype wire

/* File: design/rpms_sequencer.sv */
// Operating mode and power state sequencer for a low-power radio.
// Assumes mode field and lock-disable bit come from the host's config port,
// synchronous to clk; osc_ok and pll_ok are analog status levels.
// Contract
// - Mode field 000 sleep, 001 standby, 010 synthesizer, 011 receive, 100 transmit.
// - Going from sleep to standby the crystal oscillator is running within 5 ms.
// - Going from standby to synthesizer the PLL locks in under 0.5 ms and lock shows on the lock output.
// - Setting sleep from any mode completes shutdown within 1 ms.
// - In sleep the buffered reference clock output is held inactive.
// - A lock-disable bit of 1 forces the lock output high; 0 lets it follow PLL lock. Code: with 0 it is high in synth, rx and tx, even after a lock timeout.
`timescale 1ns/100ps
`default_nettype none
`include "rpms_cfg.svh"
module rpms_sequencer (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [2:0] main_mode_config_reg,
    input  wire logic       lock_sig_disable,
    input  wire logic       osc_ok,
    input  wire logic       pll_ok,
    input  wire logic       ref_clk_div,
    output logic            xo_enable,
    output logic            pll_enable,
    output logic            rx_enable,
    output logic            tx_enable,
    output logic            pll_lock_out,
    output logic            clk_out,
    output logic            sleeping,
    output logic            mode_error
);
    localparam int XO_CYC   = `RPMS_XO_START_US * 1000 / `RPMS_CLK_PERIOD_NS;
    localparam int PLL_CYC  = `RPMS_PLL_LOCK_US * 1000 / `RPMS_CLK_PERIOD_NS - 1;
    localparam int SHUT_CYC = `RPMS_SHUTDOWN_US * 1000 / `RPMS_CLK_PERIOD_NS - 1;

    rpms_pkg::rpms_state_t st_r;
    rpms_pkg::rpms_state_t st_nxt;
    logic                   xo_r, pll_r, rx_r, tx_r, lock_r, clko_r, slp_r, err_r;
    logic                   xo_nxt, pll_nxt, rx_nxt, tx_nxt, lock_nxt, clko_nxt, slp_nxt, err_nxt;
    logic                   tmr_load;
    logic [`RPMS_CNT_W-1:0] tmr_val;
    logic                   tmr_done;

    rpms_timer u_timer (
        .clk      (clk),
        .rstn     (rstn),
        .load     (tmr_load),
        .load_val (tmr_val),
        .done     (tmr_done)
    );

    wire is_sleep = main_mode_config_reg == `RPMS_MODE_SLEEP;

    always_comb
    begin
        st_nxt   = st_r;
        tmr_load = 1'b0;
        tmr_val  = '0;
        err_nxt  = 1'b0;
        case (st_r)
            rpms_pkg::RPMS_ST_SLEEP:
                // Undefined codes must not wake the crystal; flag them and stay asleep
                if (main_mode_config_reg > `RPMS_MODE_TX)
                    err_nxt = 1'b1;
                else if (!is_sleep)
                begin
                    st_nxt   = rpms_pkg::RPMS_ST_XO_START;
                    tmr_load = 1'b1;
                    tmr_val  = `RPMS_CNT_W'(XO_CYC - 1);
                end
            rpms_pkg::RPMS_ST_XO_START:
                if (is_sleep)
                    st_nxt = rpms_pkg::RPMS_ST_SLEEP;
                else if (osc_ok || tmr_done)
                    st_nxt = rpms_pkg::RPMS_ST_STANDBY;
            rpms_pkg::RPMS_ST_PLL_START:
                if (main_mode_config_reg != `RPMS_MODE_SYNTH)
                    st_nxt = rpms_pkg::RPMS_ST_STANDBY;
                else if (pll_ok || tmr_done)
                    st_nxt = rpms_pkg::RPMS_ST_SYNTH;
            rpms_pkg::RPMS_ST_SHUTDOWN:
                if (tmr_done)
                    st_nxt = rpms_pkg::RPMS_ST_SLEEP;
            rpms_pkg::RPMS_ST_STANDBY,
            rpms_pkg::RPMS_ST_SYNTH,
            rpms_pkg::RPMS_ST_RX,
            rpms_pkg::RPMS_ST_TX:
                case (main_mode_config_reg)
                    `RPMS_MODE_SLEEP:
                    begin
                        st_nxt   = rpms_pkg::RPMS_ST_SHUTDOWN;
                        tmr_load = 1'b1;
                        tmr_val  = `RPMS_CNT_W'(SHUT_CYC - 1);
                    end
                    `RPMS_MODE_STANDBY:
                        st_nxt = rpms_pkg::RPMS_ST_STANDBY;
                    `RPMS_MODE_SYNTH:
                        if (st_r == rpms_pkg::RPMS_ST_STANDBY)
                        begin
                            st_nxt   = rpms_pkg::RPMS_ST_PLL_START;
                            tmr_load = 1'b1;
                            tmr_val  = `RPMS_CNT_W'(PLL_CYC - 1);
                        end
                        else
                            st_nxt = rpms_pkg::RPMS_ST_SYNTH;
                    `RPMS_MODE_RX, `RPMS_MODE_TX:
                        // Host must lock first; a skipped step is flagged and held
                        if (st_r == rpms_pkg::RPMS_ST_STANDBY)
                            err_nxt = 1'b1;
                        else if (main_mode_config_reg == `RPMS_MODE_RX)
                            st_nxt = rpms_pkg::RPMS_ST_RX;
                        else
                            st_nxt = rpms_pkg::RPMS_ST_TX;
                    default:
                        err_nxt = 1'b1;
                endcase
            default:
                st_nxt = rpms_pkg::RPMS_ST_SLEEP;
        endcase
    end

    always_comb
    begin
        xo_nxt  = st_nxt != rpms_pkg::RPMS_ST_SLEEP;
        pll_nxt = st_nxt inside {rpms_pkg::RPMS_ST_PLL_START, rpms_pkg::RPMS_ST_SYNTH,
                                 rpms_pkg::RPMS_ST_RX, rpms_pkg::RPMS_ST_TX};
        rx_nxt  = st_nxt == rpms_pkg::RPMS_ST_RX;
        tx_nxt  = st_nxt == rpms_pkg::RPMS_ST_TX;
        slp_nxt = st_nxt == rpms_pkg::RPMS_ST_SLEEP;
        // Lock reported once synthesizer has settled, or in any state while lock_sig_disable is set
        lock_nxt = lock_sig_disable ? 1'b1 :
                   (st_nxt inside {rpms_pkg::RPMS_ST_SYNTH, rpms_pkg::RPMS_ST_RX,
                                   rpms_pkg::RPMS_ST_TX});
        // Clock held low through crystal start-up and shutdown too, so host never sees a runt
        clko_nxt = (st_r != rpms_pkg::RPMS_ST_SLEEP && st_r != rpms_pkg::RPMS_ST_XO_START
                    && st_r != rpms_pkg::RPMS_ST_SHUTDOWN) ? ref_clk_div : 1'b0;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r   <= rpms_pkg::RPMS_ST_SLEEP;
            xo_r   <= 1'b0;
            pll_r  <= 1'b0;
            rx_r   <= 1'b0;
            tx_r   <= 1'b0;
            lock_r <= 1'b0;
            clko_r <= 1'b0;
            slp_r  <= 1'b1;
            err_r  <= 1'b0;
        end
        else
        begin
            st_r   <= st_nxt;
            xo_r   <= xo_nxt;
            pll_r  <= pll_nxt;
            rx_r   <= rx_nxt;
            tx_r   <= tx_nxt;
            lock_r <= lock_nxt;
            clko_r <= clko_nxt;
            slp_r  <= slp_nxt;
            err_r  <= err_nxt;
        end
    end

    assign xo_enable    = xo_r;
    assign pll_enable   = pll_r;
    assign rx_enable    = rx_r;
    assign tx_enable    = tx_r;
    assign pll_lock_out = lock_r;
    assign clk_out      = clko_r;
    assign sleeping     = slp_r;
    assign mode_error   = err_r;

    // Helper: cycles spent in the current state, any state; checked only for start-up/shutdown states
    logic [`RPMS_CNT_W-1:0] dwell_r;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            dwell_r <= '0;
        else if (st_r != st_nxt)
            dwell_r <= '0;
        else
            dwell_r <= dwell_r + 1'b1;
    end

    sequence sleep_req_s;
        main_mode_config_reg == `RPMS_MODE_SLEEP;
    endsequence

    xo_bound_a: assert property (@(posedge clk) disable iff (!rstn)
        st_r == rpms_pkg::RPMS_ST_XO_START |-> dwell_r < `RPMS_CNT_W'(XO_CYC))
        else $error("crystal start exceeded 5 ms");
    pll_bound_a: assert property (@(posedge clk) disable iff (!rstn)
        st_r == rpms_pkg::RPMS_ST_PLL_START |-> dwell_r < `RPMS_CNT_W'(PLL_CYC))
        else $error("pll lock exceeded 0.5 ms");
    lock_shown_a: assert property (@(posedge clk) disable iff (!rstn)
        st_r == rpms_pkg::RPMS_ST_SYNTH && !lock_sig_disable |-> pll_lock_out)
        else $error("lock not shown in synthesizer");
    shut_bound_a: assert property (@(posedge clk) disable iff (!rstn)
        st_r == rpms_pkg::RPMS_ST_SHUTDOWN |-> dwell_r < `RPMS_CNT_W'(SHUT_CYC))
        else $error("shutdown exceeded 1 ms");
    shut_entry_a: assert property (@(posedge clk) disable iff (!rstn)
        st_r == rpms_pkg::RPMS_ST_TX ##0 sleep_req_s |=> st_r == rpms_pkg::RPMS_ST_SHUTDOWN ##1 !tx_enable)
        else $error("transmit not shut down on sleep");
    clk_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
        sleeping |-> !clk_out)
        else $error("clock output active in sleep");
    lock_force_a: assert property (@(posedge clk) disable iff (!rstn)
        lock_sig_disable |=> pll_lock_out)
        else $error("lock output not forced high");
    decode_a: assert property (@(posedge clk) disable iff (!rstn)
        st_r == rpms_pkg::RPMS_ST_SYNTH && main_mode_config_reg == `RPMS_MODE_RX |=> rx_enable && !tx_enable)
        else $error("receive mode not decoded");
    no_skip_a: assert property (@(posedge clk) disable iff (!rstn)
        st_r == rpms_pkg::RPMS_ST_STANDBY |=> !rx_enable && !tx_enable)
        else $error("radio entered rx/tx from standby");
endmodule
`default_nettype wire

/* File: verification/rpms_host_model.sv */
// Host model: steps the mode field along the legal path toward a goal.
// Assumes the bench sets goal and may force raw codes for refusal tests.
`timescale 1ns/100ps
`default_nettype none
module rpms_host_model (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [2:0] goal,
    input  wire logic       force_en,
    input  wire logic [2:0] force_val,
    input  wire logic       lock_seen,
    input  wire logic       sleeping,
    output logic [2:0]      mode,
    output logic            config_port_select_n,
    output logic            data_port_select_n,
    output logic            serial_clk
);
    // Pin levels: config port select driven low while the radio sleeps; data port select held high, serial clock held low
    assign config_port_select_n = ~sleeping;
    assign data_port_select_n   = 1'b1;
    assign serial_clk           = 1'b0;

    always @(negedge clk or negedge rstn)
    begin
        if (!rstn)
            mode <= 3'h0;
        else if (force_en)
            mode <= force_val;
        else if (goal == 3'h0 || (goal <= 3'h2 && mode != 3'h0))
            mode <= goal;
        else if (mode == 3'h0)
            mode <= 3'h1;
        else if (mode == 3'h1)
            mode <= 3'h2;
        else if (lock_seen && mode != goal)
            mode <= goal;
    end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the radio power mode sequencer.
// Assumes the host model drives the mode field; status levels come from here.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; $display("MISMATCH t=%0t got %b exp %b", $time, g, e); end end
module testbench;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [2:0]  goal = 3'h0;
    logic        force_en = 1'b0;
    logic [2:0]  force_val = 3'h0;
    logic        lsd = 1'b0;
    logic        osc_ok = 1'b0;
    logic        pll_ok = 1'b0;
    logic        ref_div = 1'b0;
    logic [2:0]  mode;
    logic        xo, pll, rx, tx, lock, clk_out, sleeping, mode_error;
    logic [5:0]  dut_vec;
    logic [31:0] seed = 32'h000089D4;
    int          failures = 0;
    int          comparisons = 0;

    assign dut_vec = {xo, pll, rx, tx, lock, sleeping};
    always #5 clk = ~clk;

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    always @(negedge clk)
        ref_div <= xorshift() > 32'h7FFFFFFF;

    // States: 0 sleep, 1 standby, 2 synth, 3 rx, 4 tx, 5 shutting down
    function automatic logic [5:0] exp_vec(int s);
        logic act;
        act = s >= 2 && s <= 4;
        return {s != 0, act, s == 3, s == 4, lsd | (act & pll_ok), s == 0};
    endfunction

    task automatic give_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic settle(int s, int lim);
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (dut_vec !== exp_vec(s) && n < lim);
        `CHK(dut_vec, exp_vec(s))
        // Only a miss ends the run early; a match on the last try carries on
        if (dut_vec !== exp_vec(s))
            give_verdict();
    endtask

    // Register lag of one edge: clk_out shows the divided reference seen at the edge
    task automatic chk_clk(bit follow);
        logic e;
        repeat (8)
        begin
            @(posedge clk);
            e = follow & ref_div;
            #1;
            `CHK(clk_out, e)
        end
        @(negedge clk);
    endtask

    task automatic refuse(logic [2:0] c, int s);
        @(negedge clk);
        force_en <= 1'b1;
        force_val <= c;
        @(negedge clk);
        repeat (2) @(posedge clk);
        #1;
        `CHK(mode_error, 1'b1)
        `CHK(dut_vec, exp_vec(s))
        @(negedge clk);
        force_en <= 1'b0;
    endtask

    rpms_sequencer i_dut (
        .clk                 (clk),
        .rstn                (rstn),
        .main_mode_config_reg(mode),
        .lock_sig_disable    (lsd),
        .osc_ok              (osc_ok),
        .pll_ok              (pll_ok),
        .ref_clk_div         (ref_div),
        .xo_enable           (xo),
        .pll_enable          (pll),
        .rx_enable           (rx),
        .tx_enable           (tx),
        .pll_lock_out        (lock),
        .clk_out             (clk_out),
        .sleeping            (sleeping),
        .mode_error          (mode_error)
    );

    rpms_host_model i_host (
        .clk                 (clk),
        .rstn                (rstn),
        .goal                (goal),
        .force_en            (force_en),
        .force_val           (force_val),
        .lock_seen           (lock),
        .sleeping            (sleeping),
        .mode                (mode),
        .config_port_select_n(),
        .data_port_select_n  (),
        .serial_clk          ()
    );

    initial
    begin
        repeat (8) @(negedge clk);
        rstn <= 1'b1;
        settle(0, 2);
        chk_clk(1'b0);
        for (int c = 5; c < 8; c++)
            refuse(c[2:0], 0);
        $display("test sleep and illegal codes done");
        goal <= 3'h1;
        settle(1, 8);
        chk_clk(1'b0);
        repeat (seed[4:0]) @(negedge clk);
        osc_ok <= 1'b1;
        repeat (3) @(negedge clk);
        chk_clk(1'b1);
        refuse(3'h3, 1);
        refuse(3'h4, 1);
        $display("test crystal start done");
        goal <= 3'h2;
        settle(2, 8);
        lsd <= 1'b1;
        settle(2, 4);
        lsd <= 1'b0;
        pll_ok <= 1'b1;
        settle(2, 4);
        $display("test lock done");
        goal <= 3'h3;
        settle(3, 8);
        goal <= 3'h1;
        settle(1, 8);
        goal <= 3'h4;
        settle(4, 20);
        $display("test rx and tx done");
        goal <= 3'h0;
        settle(5, 3);
        chk_clk(1'b0);
        settle(0, 100003);
        chk_clk(1'b0);
        $display("test shutdown done");
        give_verdict();
    end
endmodule
`default_nettype wire
